// ### pdc_cascade_stage.sv
// Next more significant stage, counting on the borrow of the stage below
`timescale 1ns/1ps
`default_nettype none

module pdc_cascade_stage (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Borrow from the less significant stage
    input wire logic count_enable_n,
    // Stage count
    output logic [7:0] count_r
);
    // Binary only: enough to prove the borrow chain, not a full counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= 8'hFF;
        end else if (!count_enable_n) begin
            count_r <= count_r - 8'h01;
        end
    end
endmodule

`default_nettype wire

// ### pdc_digit.sv
// Package of counter constants and the single decade stage of the BCD variant
// Overview of operation
// - Count falls by one per rising edge when enabled and no load or clear.
// - Count holds while count enable is high and no load or clear.
// - Zero flag goes low for one clock period at zero count while enabled.
// - Synchronous load low copies preload bits on next edge, enable ignored.
// - Asynchronous load low copies preload bits on next edge, overriding sync load and enable.
// - Clear low sets count to maximum: 99 BCD, 255 binary, overriding all.
// - Priority is clear, asynchronous load, synchronous load, then count enable.
// - All control inputs and the zero flag are active low.
// - Preload is two BCD digits, upper on 7..4, or one binary byte.
// - BCD is two cascaded decades, lower borrowing into upper; binary is one byte.
`timescale 1ns/1ps
`default_nettype none

package pdc_pkg;
    localparam int CNT_W = 8;
    localparam int DIGIT_W = 4;
    localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
    localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
    localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] MAX_BCD = 8'h99;
    localparam logic [CNT_W-1:0] MAX_BIN = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic ZERO_FLAG_IDLE = 1'b1;

    // One decade step down, wrapping zero to nine
    function automatic logic [DIGIT_W-1:0] pdc_digit_dec(input logic [DIGIT_W-1:0] q);
        return (q == DIGIT_ZERO) ? DIGIT_MAX : q - DIGIT_ONE;
    endfunction

    // Whole-counter step down in either variant
    function automatic logic [CNT_W-1:0] pdc_count_dec(input logic [CNT_W-1:0] q,
                                                        input logic bcd);
        if (bcd) begin
            return {((q[3:0] == DIGIT_ZERO) ? pdc_digit_dec(q[7:4]) : q[7:4]),
                    pdc_digit_dec(q[3:0])};
        end
        return q - CNT_ONE;
    endfunction

    function automatic logic [CNT_W-1:0] pdc_count_max(input logic bcd);
        return bcd ? MAX_BCD : MAX_BIN;
    endfunction
endpackage

module pdc_decade
    import pdc_pkg::*;
(
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic clear_to_max_n,
    // Control
    input wire logic load,
    input wire logic [DIGIT_W-1:0] load_val,
    input wire logic dec,
    // Digit state
    output var logic [DIGIT_W-1:0] digit_r
);
    logic [DIGIT_W-1:0] digit_nxt;

    always_comb begin
        if (load) begin
            digit_nxt = load_val;
        end else if (dec) begin
            digit_nxt = pdc_digit_dec(digit_r);
        end else begin
            digit_nxt = digit_r;
        end
    end

    always_ff @(posedge clk or posedge rst or negedge clear_to_max_n) begin
        if (rst) begin
            digit_r <= DIGIT_MAX;
        end else if (!clear_to_max_n) begin
            digit_r <= DIGIT_MAX;
        end else begin
            digit_r <= digit_nxt;
        end
    end
endmodule

`default_nettype wire

// ### pdc_top.sv
// Presettable eight-bit down counter with active-low zero flag
`timescale 1ns/1ps
`default_nettype none

module pdc_top
    import pdc_pkg::*;
#(
    parameter int BCD_MODE = 1
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Active-low controls
    input wire logic CLEAR_TO_MAX_N,
    input wire logic ASYNC_LOAD_N,
    input wire logic SYNC_LOAD_N,
    input wire logic COUNT_ENABLE_N,
    // Preload data
    input wire logic [CNT_W-1:0] PRELOAD_BITS,
    // Count and zero flag
    output logic [CNT_W-1:0] COUNT,
    output logic ZERO_FLAG_N
);
    localparam logic BCD = (BCD_MODE != 0);

    if (BCD_MODE != 0 && BCD_MODE != 1) begin : g_bad_mode
        $error("BCD_MODE must be 0 or 1");
    end

    logic load;
    logic counting;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_nxt;
    logic zero_flag_n_r;
    logic ctrl_live;

    // Both loads take the same data, so merging them keeps the priority intact
    assign load = !ASYNC_LOAD_N || !SYNC_LOAD_N;
    assign counting = !COUNT_ENABLE_N;
    // Checks skip edges on which reset or clear still held the flops
    assign ctrl_live = !RST && CLEAR_TO_MAX_N;

    always_comb begin
        if (load) begin
            count_nxt = PRELOAD_BITS;
        end else if (counting) begin
            count_nxt = pdc_count_dec(count_q, BCD);
        end else begin
            count_nxt = count_q;
        end
    end

    if (BCD_MODE != 0) begin : g_bcd
        logic [DIGIT_W-1:0] lower_digit;
        logic [DIGIT_W-1:0] upper_digit;

        pdc_decade u_lower (
            .clk(CLK_SYS),
            .rst(RST),
            .clear_to_max_n(CLEAR_TO_MAX_N),
            .load(load),
            .load_val(PRELOAD_BITS[3:0]),
            .dec(counting),
            .digit_r(lower_digit)
        );

        // Upper decade takes a borrow only when the lower one passes zero
        pdc_decade u_upper (
            .clk(CLK_SYS),
            .rst(RST),
            .clear_to_max_n(CLEAR_TO_MAX_N),
            .load(load),
            .load_val(PRELOAD_BITS[7:4]),
            .dec(counting && (lower_digit == DIGIT_ZERO)),
            .digit_r(upper_digit)
        );

        assign count_q = {upper_digit, lower_digit};
    end else begin : g_bin
        logic [CNT_W-1:0] bin_r;

        always_ff @(posedge CLK_SYS or posedge RST or negedge CLEAR_TO_MAX_N) begin
            if (RST) begin
                bin_r <= MAX_BIN;
            end else if (!CLEAR_TO_MAX_N) begin
                bin_r <= MAX_BIN;
            end else begin
                bin_r <= count_nxt;
            end
        end

        assign count_q = bin_r;
    end

    // Flag is registered, so it tracks the count that the same edge produces
    always_ff @(posedge CLK_SYS or posedge RST or negedge CLEAR_TO_MAX_N) begin
        if (RST) begin
            zero_flag_n_r <= ZERO_FLAG_IDLE;
        end else if (!CLEAR_TO_MAX_N) begin
            zero_flag_n_r <= ZERO_FLAG_IDLE;
        end else begin
            zero_flag_n_r <= !((count_nxt == CNT_ZERO) && counting);
        end
    end

    assign COUNT = count_q;
    assign ZERO_FLAG_N = zero_flag_n_r;

    property p_count_down;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N)
            |=> COUNT == pdc_count_dec($past(COUNT), BCD);
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not step down");

    property p_hold;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && SYNC_LOAD_N && COUNT_ENABLE_N) |=> $stable(COUNT);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while inhibited");

    property p_zero_flag;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        !ZERO_FLAG_N |-> (COUNT == CNT_ZERO);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag low at nonzero count");

    property p_zero_flag_set;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N && COUNT == CNT_ONE)
            |=> !ZERO_FLAG_N ##1 (ZERO_FLAG_N || COUNT == CNT_ZERO);
    endproperty
    a_zero_flag_set: assert property (p_zero_flag_set) else $error("zero flag missed");

    property p_sync_load;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && !SYNC_LOAD_N) |=> COUNT == $past(PRELOAD_BITS);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync load failed");

    property p_async_load;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && !ASYNC_LOAD_N) |=> COUNT == $past(PRELOAD_BITS);
    endproperty
    a_async_load: assert property (p_async_load) else $error("async load failed");

    property p_clear;
        @(posedge CLK_SYS) disable iff (RST)
        !CLEAR_TO_MAX_N |-> (COUNT == pdc_count_max(BCD)) && ZERO_FLAG_N;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reach maximum");

    property p_wrap;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N && COUNT == CNT_ZERO)
            |=> COUNT == pdc_count_max(BCD);
    endproperty
    a_wrap: assert property (p_wrap) else $error("zero did not wrap to maximum");

    property p_borrow;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && BCD && ASYNC_LOAD_N && SYNC_LOAD_N && COUNT[3:0] != DIGIT_ZERO)
            |=> COUNT[7:4] == $past(COUNT[7:4]);
    endproperty
    a_borrow: assert property (p_borrow) else $error("upper digit moved without borrow");

    property p_flag_single;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N && !ZERO_FLAG_N)
            |=> ZERO_FLAG_N;
    endproperty
    a_flag_single: assert property (p_flag_single) else $error("flag held too long");

    property p_flag_idle;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && COUNT_ENABLE_N)
            |=> ZERO_FLAG_N;
    endproperty
    a_flag_idle: assert property (p_flag_idle) else $error("flag low while idle");

    property p_flag_track;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && !COUNT_ENABLE_N)
            |=> ZERO_FLAG_N == (COUNT != CNT_ZERO);
    endproperty
    a_flag_track: assert property (p_flag_track) else $error("flag off zero");

    property p_load_order;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && !ASYNC_LOAD_N && !SYNC_LOAD_N && !COUNT_ENABLE_N)
            |=> COUNT == $past(PRELOAD_BITS);
    endproperty
    a_load_order: assert property (p_load_order) else $error("load order wrong");

    property p_load_no_en;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && !SYNC_LOAD_N && COUNT_ENABLE_N)
            |=> COUNT == $past(PRELOAD_BITS);
    endproperty
    a_load_no_en: assert property (p_load_no_en) else $error("load used enable");

    property p_low_wrap;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && BCD && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N
            && COUNT[3:0] == DIGIT_ZERO) |=> COUNT[3:0] == DIGIT_MAX;
    endproperty
    a_low_wrap: assert property (p_low_wrap) else $error("lower digit wrap");

    property p_up_borrow;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && BCD && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N
            && COUNT[3:0] == DIGIT_ZERO) |=> COUNT[7:4] == pdc_digit_dec($past(COUNT[7:4]));
    endproperty
    a_up_borrow: assert property (p_up_borrow) else $error("upper borrow");

    property p_bin_step;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && !BCD && ASYNC_LOAD_N && SYNC_LOAD_N && !COUNT_ENABLE_N)
            |=> COUNT == CNT_W'($past(COUNT) - CNT_ONE);
    endproperty
    a_bin_step: assert property (p_bin_step) else $error("binary step");

    property p_zero_load;
        @(posedge CLK_SYS) disable iff (RST || !CLEAR_TO_MAX_N)
        (ctrl_live && ASYNC_LOAD_N && !SYNC_LOAD_N && !COUNT_ENABLE_N
            && PRELOAD_BITS == CNT_ZERO) |=> !ZERO_FLAG_N;
    endproperty
    a_zero_load: assert property (p_zero_load) else $error("zero load flag");
endmodule

`default_nettype wire

// ### tb_presettable_down_counter_8bit.sv
// Self-checking bench for both counter variants and a cascaded stage
`timescale 1ns/1ps
`default_nettype none

module tb_presettable_down_counter_8bit
    import pdc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, clr_n = 1'b1, ald_n = 1'b1, sld_n = 1'b1, cen_n = 1'b1;
    logic [7:0] pre_d = 8'h00, pre_b = 8'h00, cnt_d, cnt_b, casc;
    logic zf_d, zf_b, ef_d = 1'b1, ef_b = 1'b1;
    logic [7:0] exp_d = MAX_BCD, exp_b = MAX_BIN, exp_c = MAX_BIN;
    int n_errors = 0, compares = 0;

    initial begin
        forever #50 clk = ~clk;
    end

    pdc_top #(.BCD_MODE(1)) dut (.CLK_SYS(clk), .RST(rst), .CLEAR_TO_MAX_N(clr_n),
        .ASYNC_LOAD_N(ald_n), .SYNC_LOAD_N(sld_n), .COUNT_ENABLE_N(cen_n),
        .PRELOAD_BITS(pre_d), .COUNT(cnt_d), .ZERO_FLAG_N(zf_d));
    pdc_top #(.BCD_MODE(0)) dut_bin (.CLK_SYS(clk), .RST(rst), .CLEAR_TO_MAX_N(clr_n),
        .ASYNC_LOAD_N(ald_n), .SYNC_LOAD_N(sld_n), .COUNT_ENABLE_N(cen_n),
        .PRELOAD_BITS(pre_b), .COUNT(cnt_b), .ZERO_FLAG_N(zf_b));
    pdc_cascade_stage casc_i (.clk(clk), .rst(rst), .count_enable_n(zf_d), .count_r(casc));

    // Invalid digits simply step down like valid ones
    function automatic logic [7:0] bcd_dec(input logic [7:0] q);
        logic [3:0] lo, hi;
        lo = (q[3:0] == 4'h0) ? 4'h9 : q[3:0] - 4'h1;
        hi = (q[3:0] != 4'h0) ? q[7:4] : (q[7:4] == 4'h0) ? 4'h9 : q[7:4] - 4'h1;
        return {hi, lo};
    endfunction

    function automatic logic [7:0] nxt(input logic [7:0] q, input logic bcd, input logic [7:0] p);
        if (!ald_n || !sld_n) return p;
        if (cen_n) return q;
        return bcd ? bcd_dec(q) : q - 8'h01;
    endfunction

    always @(posedge clk) begin
        if (rst || !clr_n) begin
            exp_d <= MAX_BCD;
            exp_b <= MAX_BIN;
            ef_d <= 1'b1;
            ef_b <= 1'b1;
        end else begin
            exp_d <= nxt(exp_d, 1'b1, pre_d);
            exp_b <= nxt(exp_b, 1'b0, pre_b);
            ef_d <= !(nxt(exp_d, 1'b1, pre_d) == 8'h00 && !cen_n);
            ef_b <= !(nxt(exp_b, 1'b0, pre_b) == 8'h00 && !cen_n);
        end
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Clear is asynchronous, so the expectation follows its live level
    always @(negedge clk) begin
        if (!rst) begin
            check("bcd", {zf_d, cnt_d}, clr_n ? {ef_d, exp_d} : {1'b1, MAX_BCD});
            check("bin", {zf_b, cnt_b}, clr_n ? {ef_b, exp_b} : {1'b1, MAX_BIN});
            check("cascade", {1'b0, casc}, {1'b0, exp_c});
            if (clr_n && !ef_d) begin
                exp_c <= exp_c - 8'h01;
            end
        end
    end

    // Controls packed as clear, async load, sync load, enable
    task automatic drv(input logic [3:0] c, input logic [7:0] p, input int n);
        repeat (n) begin
            @(posedge clk);
            {clr_n, ald_n, sld_n, cen_n} <= c;
            pre_d <= p;
            pre_b <= p;
        end
    endtask

    task automatic results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(95));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        drv(4'b1101, 8'h02, 1);
        drv(4'b1110, 8'h77, 4);
        drv(4'b1111, 8'h33, 2);
        drv(4'b1100, 8'h00, 2);
        drv(4'b1000, 8'h45, 1);
        drv(4'b1010, 8'h37, 1);
        drv(4'b0000, 8'h12, 2);
        repeat (2000) begin
            @(posedge clk);
            clr_n <= ($urandom % 16) != 0;
            ald_n <= ($urandom % 8) != 0;
            sld_n <= ($urandom % 8) != 0;
            cen_n <= ($urandom % 4) == 0;
            pre_d <= {4'($urandom % 10), 4'($urandom % 10)};
            pre_b <= 8'($urandom);
        end
        drv(4'b1111, 8'h00, 5);
        results();
    end
endmodule

`default_nettype wire
